//--- tb/fpp_flash_tb.sv
`timescale 1ns/1ps
`include "fpp_params.svh"
module fpp_flash_tb;
  localparam int unsigned PROG = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        strap, rc, we_n, oe_n, dq_oe, rst_n, init_n, wp_n, bbp_n;
  logic        pmode, smode, op_busy, rd_seen;
  logic [10:0] apins;
  logic [7:0]  dq_out, dq_drv, dq_wire, rd_val, r1, d;
  logic [19:0] a;
  logic [64:0] apb_q[$];
  logic [15:0] pin_q[$];
  int          num_errors, checks_done, cyc, busy_cnt;

  assign dq_wire = dq_oe ? dq_out : dq_drv;

  fpp_flash #(.PROG_CYC(PROG), .ERASE_CYC(50), .CHIP_CYC(50)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interface_select_strap(strap), .muxed_address_pins(apins), .row_col_sel(rc),
    .write_enable_n(we_n), .output_enable_n(oe_n), .data_pins_in(dq_wire),
    .data_pins_out(dq_out), .data_pins_oe(dq_oe), .dev_reset_n(rst_n), .dev_init_n(init_n),
    .write_protect_n(wp_n), .boot_block_protect_n(bbp_n), .parallel_program_mode(pmode),
    .serial_host_mode(smode), .op_busy(op_busy));

  fpp_programmer i_prog (
    .pclk(pclk), .addr_pins(apins), .rc_sel(rc), .we_n(we_n), .oe_n(oe_n),
    .dq_drive(dq_drv), .dq_wire(dq_wire), .rd_val(rd_val), .rd_seen(rd_seen));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] ad, input logic [31:0] m, input logic [32:0] e);
    apb_q.push_back({m, e});
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic pin_rd(input logic [19:0] ad, input logic [7:0] m, input logic [7:0] e);
    pin_q.push_back({m, e & m});
    i_prog.rd(ad);
  endtask

  task automatic unlock();
    i_prog.wr(`FPP_UNL_ADDR1, `FPP_UNL_DATA1);
    i_prog.wr(`FPP_UNL_ADDR2, `FPP_UNL_DATA2);
  endtask

  task automatic erase(input logic [19:0] ad, input logic [7:0] c);
    unlock();
    i_prog.wr(`FPP_UNL_ADDR1, `FPP_CMD_ERASE);
    unlock();
    i_prog.wr(ad, c);
  endtask

  task automatic wait_idle();
    while (op_busy !== 1'b0) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask

  always @(posedge pclk) begin
    if (op_busy) busy_cnt++;
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata & apb_q[0][64:33]}, apb_q[0][32:0]);
      void'(apb_q.pop_front());
    end
    if (rd_seen) begin
      check({25'h0, rd_val & pin_q[0][15:8]}, {25'h0, pin_q[0][7:0]});
      void'(pin_q.pop_front());
    end
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, wp_n, bbp_n, rst_n, init_n, strap} = 6'h1F;
    rnd = 32'h74D6;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    rd_reg(`FPP_REG_CTRL, 32'hFFFFFFFF, 33'h1);
    rd_reg(`FPP_REG_STATUS, 32'h7F, 33'h2);
    rd_reg(12'h010, 32'hFFFFFFFF, {1'b1, 32'h0});
    check({32'h0, dq_oe}, 33'h0);
    $display("test reset done");
    rnd = xs(rnd);
    a = {1'b0, rnd[18:0]};
    d = rnd[27:20];
    busy_cnt = 0;
    erase(a, `FPP_CMD_SECT);
    wait_idle();
    check({32'h0, busy_cnt >= 4097}, 33'h1);
    rd_reg(`FPP_REG_STATUS, 32'h7F, 33'h0A);
    pin_rd({a[19:12], 12'hFFF}, 8'hFF, `FPP_ERASED);
    $display("test sector erase done");
    for (int i = 0; i < 2; i++) begin
      unlock();
      i_prog.wr(`FPP_UNL_ADDR1, `FPP_CMD_PROG);
      busy_cnt = 0;
      i_prog.wr(a, d);
      pin_rd(a, 8'hBF, {~d[7], 7'h0});
      r1 = rd_val;
      pin_rd(a, 8'hBF, {~d[7], 7'h0});
      check({32'h0, r1[6] ^ rd_val[6]}, 33'h1);
      wait_idle();
      check({32'h0, busy_cnt >= PROG && busy_cnt <= PROG + 2}, 33'h1);
      rd_reg(`FPP_REG_STATUS, 32'h7F, 33'h0A);
      rd_reg(`FPP_REG_ADDR, 32'hFFFFF, {13'h0, a});
      pin_rd(a, 8'hFF, d);
    end
    $display("test program done");
    i_prog.wr(a ^ 20'h1, 8'h00);
    check({32'h0, op_busy}, 33'h0);
    pin_rd(a ^ 20'h1, 8'hFF, `FPP_ERASED);
    apb(1'b1, `FPP_REG_CTRL, 32'h0);
    i_prog.wr(a ^ 20'h1, 8'h5A);
    wait_idle();
    pin_rd(a ^ 20'h1, 8'hFF, 8'h5A);
    apb(1'b1, `FPP_REG_CTRL, 32'h1);
    $display("test guard done");
    bbp_n <= 1'b0;
    erase(20'hF0000, `FPP_CMD_BLK);
    check({32'h0, op_busy}, 33'h0);
    rd_reg(`FPP_REG_STATUS, 32'h7, 33'h6);
    apb(1'b1, `FPP_REG_STATUS, 32'h4);
    bbp_n <= 1'b1;
    wp_n  <= 1'b0;
    erase(`FPP_UNL_ADDR1, `FPP_CMD_CHIP);
    rd_reg(`FPP_REG_STATUS, 32'h7, 33'h6);
    apb(1'b1, `FPP_REG_STATUS, 32'h4);
    rd_reg(`FPP_REG_STATUS, 32'h4, 33'h0);
    wp_n  <= 1'b1;
    $display("test protect done");
    unlock();
    i_prog.wr(`FPP_UNL_ADDR1, `FPP_CMD_PROG);
    i_prog.wr(a, d);
    check({32'h0, op_busy}, 33'h1);
    strap  <= 1'b0;
    init_n <= 1'b0;
    repeat (10) @(posedge pclk);
    check({32'h0, op_busy}, 33'h0);
    init_n <= 1'b1;
    repeat (20) @(posedge pclk);
    check({31'h0, pmode, smode}, 33'h1);
    busy_cnt = 0;
    erase(`FPP_UNL_ADDR1, `FPP_CMD_CHIP);
    check(33'(busy_cnt), 33'h0);
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (10) @(posedge pclk);
    rst_n <= 1'b1;
    repeat (20) @(posedge pclk);
    check({31'h0, pmode, smode}, 33'h2);
    $display("test mode done");
    print_verdict();
  end
endmodule

//--- tb/fpp_programmer.sv
`timescale 1ns/1ps
module fpp_programmer (
  // clock
  input  wire logic        pclk,
  // pins towards the device
  output logic      [10:0] addr_pins,
  output logic             rc_sel,
  output logic             we_n,
  output logic             oe_n,
  output logic      [7:0]  dq_drive,
  // resolved data wire and read result
  input  wire logic [7:0]  dq_wire,
  output logic      [7:0]  rd_val,
  output logic             rd_seen
);
  initial begin
    addr_pins = 11'h000;
    rc_sel    = 1'b0;
    we_n      = 1'b1;
    oe_n      = 1'b1;
    dq_drive  = 8'h00;
    rd_val    = 8'h00;
    rd_seen   = 1'b0;
  end

  // pins pass a synchroniser, so every phase is held well past its latency
  task automatic hold();
    repeat (8) @(posedge pclk);
  endtask

  task automatic set_addr(input logic [19:0] a);
    @(posedge pclk);
    addr_pins <= a[10:0];
    rc_sel    <= 1'b0;
    hold();
    rc_sel    <= 1'b1;
    hold();
    addr_pins <= {2'h0, a[19:11]};
    hold();
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    set_addr(a);
    dq_drive <= d;
    we_n     <= 1'b0;
    hold();
    we_n     <= 1'b1;
    hold();
    // released line shows the inverse, not the old byte
    dq_drive <= ~d;
    rc_sel   <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a);
    set_addr(a);
    oe_n    <= 1'b0;
    hold();
    rd_val  <= dq_wire;
    rd_seen <= 1'b1;
    @(posedge pclk);
    rd_seen <= 1'b0;
    oe_n    <= 1'b1;
    hold();
  endtask
endmodule

//--- verilog/fpp_flash.sv
`timescale 1ns/1ps
`include "fpp_params.svh"

// Function
// - strap high parallel port, low serial host
// - row and column halves share eleven pins
// - write cycle address held in latch
// - write cycle data byte held in latch
// - output enable high floats data pins
// - one byte wide array, byte access
// - separate 4K sector and 64K block erase
// - chip erase only in parallel mode
// - boot block pin and array pin protect
// - byte program within 20 us
// - each operation one self-timed pulse
// - data polling and toggle bit status
// - unlock command sequence guards writes
// - fixed durations, no wear dependence
// - serial host mode flagged for serial port
// - either reset pin low resets alike
module fpp_flash #(
  parameter int unsigned ADDR_W    = `FPP_ADDR_W,
  parameter int unsigned PROG_CYC  = `FPP_PROG_CYC,
  parameter int unsigned ERASE_CYC = `FPP_ERASE_CYC,
  parameter int unsigned CHIP_CYC  = `FPP_CHIP_CYC
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // parallel port pins
  input  wire logic        interface_select_strap,
  input  wire logic [10:0] muxed_address_pins,
  input  wire logic        row_col_sel,
  input  wire logic        write_enable_n,
  input  wire logic        output_enable_n,
  input  wire logic [7:0]  data_pins_in,
  output logic      [7:0]  data_pins_out,
  output logic             data_pins_oe,
  // reset and protect pins
  input  wire logic        dev_reset_n,
  input  wire logic        dev_init_n,
  input  wire logic        write_protect_n,
  input  wire logic        boot_block_protect_n,
  // mode and state
  output logic             parallel_program_mode,
  output logic             serial_host_mode,
  output logic             op_busy
);
  localparam int unsigned COL_W = ADDR_W - `FPP_ROW_W;

  fpp_pin_if pin ();

  fpp_pin_sync #(.W(`FPP_PIN_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({interface_select_strap, muxed_address_pins, row_col_sel, write_enable_n,
               output_enable_n, data_pins_in, dev_reset_n, dev_init_n, write_protect_n,
               boot_block_protect_n}),
    .p       (pin.src)
  );

  logic dev_rst;
  assign dev_rst = !pin.rst_n || !pin.init_n;

  // pin latch state
  logic              mode_q, mode_d, sh_q, sh_d;
  logic [2:0]        init_q, init_d;
  logic              rc_q, we_q, oe_q;
  logic [10:0]       row_q, row_d;
  logic [ADDR_W-1:0] addr_q, addr_d, rd_addr;
  logic [7:0]        wdata_q, wdata_d;
  logic              pp, we_fall, we_rise, oe_fall;

  assign pp      = mode_q && (init_q == `FPP_INIT_DONE);
  assign we_fall = we_q && !pin.we_n;
  assign we_rise = !we_q && pin.we_n;
  assign oe_fall = oe_q && !pin.oe_n;
  assign rd_addr = {pin.addr[COL_W-1:0], row_q};

  always_comb begin
    mode_d  = mode_q;
    init_d  = init_q;
    row_d   = row_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    if (dev_rst) begin
      init_d = 3'h0;
    end else if (init_q != `FPP_INIT_DONE) begin
      init_d = init_q + 3'h1;
    end
    if (dev_rst || init_q != `FPP_INIT_DONE) begin
      mode_d = pin.strap;
    end
    sh_d = !mode_d;
    if (pp && !rc_q && pin.rc) begin
      row_d = pin.addr;
    end
    if (pp && we_fall) begin
      addr_d = rd_addr;
    end
    if (pp && we_rise) begin
      wdata_d = pin.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= 1'b0;
      sh_q    <= 1'b0;
      init_q  <= 3'h0;
      rc_q    <= 1'b1;
      we_q    <= 1'b1;
      oe_q    <= 1'b1;
      row_q   <= 11'h000;
      addr_q  <= '0;
      wdata_q <= 8'h00;
    end else begin
      mode_q  <= mode_d;
      sh_q    <= sh_d;
      init_q  <= init_d;
      rc_q    <= pin.rc;
      we_q    <= pin.we_n;
      oe_q    <= pin.oe_n;
      row_q   <= row_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
    end
  end

  // command and operation state
  fpp_pkg::fpp_cmd_t       cmd_q, cmd_d;
  fpp_pkg::fpp_op_t        op_q, op_d, op_n;
  logic                    busy_q, busy_d, sweep_q, sweep_d;
  logic [`FPP_CNT_W-1:0]   cnt_q, cnt_d;
  logic [ADDR_W-1:0]       ptr_q, ptr_d, end_q, end_d;
  logic                    poll7_q, poll7_d, tog_q, tog_d;
  logic                    guard_q, perr_set, done_set, go, start, allowed, is_boot;
  logic                    a1, a2, mem_we;
  logic [ADDR_W-1:0]       mem_a;
  logic [7:0]              mem_wd;
  logic [7:0]              mem [0:(1<<ADDR_W)-1];

  assign a1      = addr_q == ADDR_W'(`FPP_UNL_ADDR1);
  assign a2      = addr_q == ADDR_W'(`FPP_UNL_ADDR2);
  assign is_boot = &addr_q[ADDR_W-1:`FPP_BLK_BITS];

  always_comb begin
    cmd_d    = cmd_q;
    op_n     = fpp_pkg::FPP_OP_NONE;
    go       = 1'b0;
    if (we_rise && pp && !busy_q && !dev_rst) begin
      cmd_d = fpp_pkg::FPP_CS_IDLE;
      unique case (cmd_q)
        fpp_pkg::FPP_CS_IDLE: begin
          if (a1 && pin.data == `FPP_UNL_DATA1) begin
            cmd_d = fpp_pkg::FPP_CS_U1;
          end else if (!guard_q) begin
            go   = 1'b1;
            op_n = fpp_pkg::FPP_OP_PROG;
          end
        end
        fpp_pkg::FPP_CS_U1: begin
          if (a2 && pin.data == `FPP_UNL_DATA2) cmd_d = fpp_pkg::FPP_CS_U2;
        end
        fpp_pkg::FPP_CS_U2: begin
          if (a1 && pin.data == `FPP_CMD_PROG) cmd_d = fpp_pkg::FPP_CS_PROG;
          if (a1 && pin.data == `FPP_CMD_ERASE) cmd_d = fpp_pkg::FPP_CS_E1;
        end
        fpp_pkg::FPP_CS_PROG: begin
          go   = 1'b1;
          op_n = fpp_pkg::FPP_OP_PROG;
        end
        fpp_pkg::FPP_CS_E1: begin
          if (a1 && pin.data == `FPP_UNL_DATA1) cmd_d = fpp_pkg::FPP_CS_E2;
        end
        fpp_pkg::FPP_CS_E2: begin
          if (a2 && pin.data == `FPP_UNL_DATA2) cmd_d = fpp_pkg::FPP_CS_E3;
        end
        fpp_pkg::FPP_CS_E3: begin
          go = 1'b1;
          if (pin.data == `FPP_CMD_SECT) begin
            op_n = fpp_pkg::FPP_OP_SECT;
          end else if (pin.data == `FPP_CMD_BLK) begin
            op_n = fpp_pkg::FPP_OP_BLK;
          end else if (a1 && pin.data == `FPP_CMD_CHIP && pp) begin
            op_n = fpp_pkg::FPP_OP_CHIP;
          end else begin
            go = 1'b0;
          end
        end
      endcase
    end
    if (dev_rst) cmd_d = fpp_pkg::FPP_CS_IDLE;
  end

  always_comb begin
    if (op_n == fpp_pkg::FPP_OP_CHIP) begin
      allowed = pin.wp_n && pin.bbp_n;
    end else begin
      allowed = is_boot ? pin.bbp_n : pin.wp_n;
    end
    start    = go && allowed;
    perr_set = go && !allowed;
    busy_d   = busy_q;
    op_d     = op_q;
    cnt_d    = cnt_q;
    sweep_d  = sweep_q;
    ptr_d    = ptr_q;
    end_d    = end_q;
    poll7_d  = poll7_q;
    tog_d    = tog_q;
    done_set = 1'b0;
    if (start) begin
      busy_d  = 1'b1;
      op_d    = op_n;
      sweep_d = op_n != fpp_pkg::FPP_OP_PROG;
      poll7_d = (op_n == fpp_pkg::FPP_OP_PROG) ? pin.data[7] : 1'b1;
      unique case (op_n)
        fpp_pkg::FPP_OP_SECT: begin
          cnt_d = `FPP_CNT_W'(ERASE_CYC - 1);
          ptr_d = {addr_q[ADDR_W-1:`FPP_SECT_BITS], {`FPP_SECT_BITS{1'b0}}};
          end_d = {addr_q[ADDR_W-1:`FPP_SECT_BITS], {`FPP_SECT_BITS{1'b1}}};
        end
        fpp_pkg::FPP_OP_BLK: begin
          cnt_d = `FPP_CNT_W'(ERASE_CYC - 1);
          ptr_d = {addr_q[ADDR_W-1:`FPP_BLK_BITS], {`FPP_BLK_BITS{1'b0}}};
          end_d = {addr_q[ADDR_W-1:`FPP_BLK_BITS], {`FPP_BLK_BITS{1'b1}}};
        end
        fpp_pkg::FPP_OP_CHIP: begin
          cnt_d = `FPP_CNT_W'(CHIP_CYC - 1);
          ptr_d = '0;
          end_d = '1;
        end
        default: begin
          cnt_d = `FPP_CNT_W'(PROG_CYC - 1);
        end
      endcase
    end else if (busy_q) begin
      if (cnt_q != '0) cnt_d = cnt_q - `FPP_CNT_W'(1);
      if (sweep_q) begin
        ptr_d = ptr_q + ADDR_W'(1);
        if (ptr_q == end_q) sweep_d = 1'b0;
      end
      if (cnt_q == '0 && !sweep_q) begin
        busy_d   = 1'b0;
        op_d     = fpp_pkg::FPP_OP_NONE;
        done_set = 1'b1;
      end
      if (oe_fall) tog_d = !tog_q;
    end
    if (dev_rst) begin
      busy_d  = 1'b0;
      sweep_d = 1'b0;
      op_d    = fpp_pkg::FPP_OP_NONE;
    end
    mem_we = (start && op_n == fpp_pkg::FPP_OP_PROG) || (busy_q && sweep_q && !dev_rst);
    mem_a  = start ? addr_q : ptr_q;
    mem_wd = start ? (mem[addr_q] & pin.data) : `FPP_ERASED;
  end

  always_ff @(posedge pclk) begin
    if (mem_we) mem[mem_a] <= mem_wd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q   <= fpp_pkg::FPP_CS_IDLE;
      op_q    <= fpp_pkg::FPP_OP_NONE;
      busy_q  <= 1'b0;
      sweep_q <= 1'b0;
      cnt_q   <= '0;
      ptr_q   <= '0;
      end_q   <= '0;
      poll7_q <= 1'b0;
      tog_q   <= 1'b0;
    end else begin
      cmd_q   <= cmd_d;
      op_q    <= op_d;
      busy_q  <= busy_d;
      sweep_q <= sweep_d;
      cnt_q   <= cnt_d;
      ptr_q   <= ptr_d;
      end_q   <= end_d;
      poll7_q <= poll7_d;
      tog_q   <= tog_d;
    end
  end

  // data pins and apb
  logic [7:0]  dout_d;
  logic        doe_d, perr_q, perr_d, done_q, done_d, guard_d;
  logic        pready_d, pslverr_d, setup, acc;
  logic [31:0] prdata_d;

  assign setup = psel && !penable;
  assign acc   = psel && penable && pready;

  always_comb begin
    doe_d  = pp && !pin.oe_n && pin.we_n;
    dout_d = busy_q ? {!poll7_q, tog_q, 6'h00} : mem[rd_addr];
    guard_d   = guard_q;
    perr_d    = perr_q;
    done_d    = done_q;
    pready_d  = setup;
    pslverr_d = 1'b0;
    prdata_d  = prdata;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      unique case (paddr)
        `FPP_REG_CTRL:   prdata_d[`FPP_CTRL_GUARD] = guard_q;
        `FPP_REG_STATUS: prdata_d[7:0] = {1'b0, op_q, done_q, perr_q, pp, busy_q};
        `FPP_REG_ADDR:   prdata_d[ADDR_W-1:0] = addr_q;
        default:         pslverr_d = 1'b1;
      endcase
    end
    if (acc && pwrite && paddr == `FPP_REG_CTRL) guard_d = pwdata[`FPP_CTRL_GUARD];
    if (acc && pwrite && paddr == `FPP_REG_STATUS) begin
      if (pwdata[`FPP_ST_PERR]) perr_d = 1'b0;
      if (pwdata[`FPP_ST_DONE]) done_d = 1'b0;
    end
    if (perr_set) perr_d = 1'b1;
    if (done_set) done_d = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pins_out         <= 8'h00;
      data_pins_oe          <= 1'b0;
      guard_q               <= `FPP_CTRL_RST;
      perr_q                <= 1'b0;
      done_q                <= 1'b0;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      prdata                <= 32'h0000_0000;
      parallel_program_mode <= 1'b0;
      serial_host_mode      <= 1'b0;
      op_busy               <= 1'b0;
    end else begin
      data_pins_out         <= dout_d;
      data_pins_oe          <= doe_d;
      guard_q               <= guard_d;
      perr_q                <= perr_d;
      done_q                <= done_d;
      pready                <= pready_d;
      pslverr               <= pslverr_d;
      prdata                <= prdata_d;
      parallel_program_mode <= mode_d && (init_d == `FPP_INIT_DONE);
      serial_host_mode      <= sh_q && (init_q == `FPP_INIT_DONE);
      op_busy               <= busy_d;
    end
  end

  // checks
  logic [`FPP_CNT_W-1:0] len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) len_q <= '0;
    else len_q <= busy_q ? len_q + `FPP_CNT_W'(1) : '0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_prog_end;
    $fell(busy_q) && $past(op_q) == fpp_pkg::FPP_OP_PROG && !$past(dev_rst);
  endsequence

  a_apb_ready_one: assert property (s_apb_setup |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");
  a_mode_held: assert property (pp && !dev_rst |=> $stable(mode_q))
    else $error("mode changed during operation");
  a_row_latch: assert property (pp && !rc_q && pin.rc |=> row_q == $past(pin.addr))
    else $error("row half not captured");
  a_addr_latch: assert property (pp && we_fall |=> addr_q == $past(rd_addr))
    else $error("write address not latched");
  a_data_latch: assert property (pp && we_rise |=> wdata_q == $past(pin.data))
    else $error("write data not latched");
  a_data_float: assert property (pin.oe_n |=> !data_pins_oe)
    else $error("data driven with output enable high");
  a_prog_fixed: assert property (s_prog_end |-> len_q == `FPP_CNT_W'(PROG_CYC))
    else $error("program pulse length wrong");
  a_prog_max: assert property (s_prog_end |-> len_q <= `FPP_CNT_W'(`FPP_PROG_MAX_CYC))
    else $error("program exceeded longest time");
  a_chip_mode: assert property (start && op_n == fpp_pkg::FPP_OP_CHIP |-> pp)
    else $error("chip erase outside parallel mode");
  a_boot_guard: assert property (start && is_boot |-> pin.bbp_n)
    else $error("boot block written while protected");
  a_poll_msb: assert property (busy_q && doe_d |=> data_pins_out[7] == !poll7_q)
    else $error("poll bit not inverted data");
  a_toggle_flip: assert property (busy_q && oe_fall && !dev_rst |=> tog_q != $past(tog_q))
    else $error("toggle bit did not flip");
  a_reset_abort: assert property (dev_rst |=> !busy_q && cmd_q == fpp_pkg::FPP_CS_IDLE)
    else $error("pin reset did not abort");
endmodule

//--- verilog/fpp_params.svh
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH

// array geometry
`define FPP_ADDR_W       20
`define FPP_ROW_W        11
`define FPP_SECT_BITS    12
`define FPP_BLK_BITS     16
`define FPP_PIN_W        27

// timing
`define FPP_CLK_MHZ      200
`define FPP_PROG_NS      14000
`define FPP_PROG_MAX_NS  20000
`define FPP_ERASE_US     18000
`define FPP_CHIP_US      70000
`define FPP_PROG_CYC     ((`FPP_PROG_NS * `FPP_CLK_MHZ) / 1000)
`define FPP_PROG_MAX_CYC ((`FPP_PROG_MAX_NS * `FPP_CLK_MHZ) / 1000)
`define FPP_ERASE_CYC    (`FPP_ERASE_US * `FPP_CLK_MHZ)
`define FPP_CHIP_CYC     (`FPP_CHIP_US * `FPP_CLK_MHZ)
`define FPP_CNT_W        24
`define FPP_INIT_DONE    3'h7

// command sequence
`define FPP_UNL_ADDR1    20'h05555
`define FPP_UNL_ADDR2    20'h02AAA
`define FPP_UNL_DATA1    8'hAA
`define FPP_UNL_DATA2    8'h55
`define FPP_CMD_PROG     8'hA0
`define FPP_CMD_ERASE    8'h80
`define FPP_CMD_SECT     8'h30
`define FPP_CMD_BLK      8'h50
`define FPP_CMD_CHIP     8'h10
`define FPP_ERASED       8'hFF

// apb registers
`define FPP_REG_CTRL     12'h000
`define FPP_REG_STATUS   12'h004
`define FPP_REG_ADDR     12'h008
`define FPP_CTRL_GUARD   0
`define FPP_CTRL_RST     1'b1
`define FPP_ST_BUSY      0
`define FPP_ST_PP        1
`define FPP_ST_PERR      2
`define FPP_ST_DONE      3
`define FPP_ST_OP        4

`endif

//--- verilog/fpp_pin_if.sv
`timescale 1ns/1ps
interface fpp_pin_if;
  logic        strap;
  logic [10:0] addr;
  logic        rc;
  logic        we_n;
  logic        oe_n;
  logic [7:0]  data;
  logic        rst_n;
  logic        init_n;
  logic        wp_n;
  logic        bbp_n;
  modport src (output strap, addr, rc, we_n, oe_n, data, rst_n, init_n, wp_n, bbp_n);
  modport dst (input strap, addr, rc, we_n, oe_n, data, rst_n, init_n, wp_n, bbp_n);
endinterface

//--- verilog/fpp_pin_sync.sv
`timescale 1ns/1ps
`include "fpp_params.svh"
module fpp_pin_sync #(
  parameter int unsigned W = `FPP_PIN_W
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw pins
  input  wire logic [W-1:0] raw,
  // filtered levels
  fpp_pin_if.src            p
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;

  // level moves only once second and third stage agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      lvl_q <= '1;
    end else begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign {p.strap, p.addr, p.rc, p.we_n, p.oe_n, p.data,
          p.rst_n, p.init_n, p.wp_n, p.bbp_n} = lvl_q;
endmodule

//--- verilog/fpp_pkg.sv
package fpp_pkg;

  typedef enum logic [2:0] {
    FPP_OP_NONE,
    FPP_OP_PROG,
    FPP_OP_SECT,
    FPP_OP_BLK,
    FPP_OP_CHIP
  } fpp_op_t;

  typedef enum logic [2:0] {
    FPP_CS_IDLE,
    FPP_CS_U1,
    FPP_CS_U2,
    FPP_CS_PROG,
    FPP_CS_E1,
    FPP_CS_E2,
    FPP_CS_E3
  } fpp_cmd_t;

endpackage
